/* File: hw/dpram_host.sv */
// host controller for one port of a two-port static ram with busy and flag space
// assumes device pins sampled synchronously; busy_n is the device's busy for this port
`timescale 1ns/1ps
module dpram_host
    import dpram_host_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // command side
    input wire logic cmd_valid,
    input wire cmd_t cmd,
    output logic cmd_ready,
    // answer side
    output logic rsp_valid,
    output rsp_t rsp,
    // device pins
    output pins_t pins,
    output logic [DATA_W-1:0] data_out,
    output logic data_oe_n,
    input wire logic [DATA_W-1:0] data_in,
    input wire logic busy_n
);
    ////////////////////////////////////////////////////////////////////////////////
    state_t st_q;
    cmd_t cmd_q;
    logic phase_rd_q;
    logic ready_q;
    pins_t pins_q;
    logic [DATA_W-1:0] data_out_q;
    logic data_oe_n_q;
    rsp_t rsp_q;
    logic rsp_valid_q;

    logic t_done;
    logic t_load;
    logic [TIMER_W-1:0] t_val;
    logic is_write;
    logic is_array;
    logic is_take;
    logic accept;
    logic setup_done;
    logic write_done;
    logic read_done;
    logic recov_done;
    logic again;
    logic wr_act;

    function automatic logic [TIMER_W-1:0] tcnt(input int unsigned c);
        return c[TIMER_W-1:0];
    endfunction : tcnt

    cycle_timer u_timer (
        .clk(clk),
        .rst(rst),
        .load(t_load),
        .load_val(t_val),
        .done(t_done)
    );

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        is_take = (cmd_q.op == OP_FLAG_TAKE);
        is_array = (cmd_q.op == OP_RD) || (cmd_q.op == OP_WR);
        is_write = (cmd_q.op == OP_WR) || (cmd_q.op == OP_FLAG_WR) || (is_take && !phase_rd_q);
        accept = (st_q == ST_IDLE) && cmd_valid && ready_q;
        setup_done = (st_q == ST_SETUP) && t_done;
        write_done = (st_q == ST_WRITE) && busy_n && t_done;
        read_done = (st_q == ST_READ) && busy_n && t_done;
        recov_done = (st_q == ST_RECOV) && t_done;
        // a take goes on to read back, and keeps reading until the flag is ours
        again = recov_done && is_take && !(phase_rd_q && rsp_q.flag_held);
        wr_act = !pins_q.rw_n && (!pins_q.ce_n || !pins_q.flag_space_sel_n);
    end

    always_comb begin
        t_load = 1'b1;
        t_val = tcnt(PRIORITY_CYC);
        if (accept || again) begin
            t_val = tcnt(PRIORITY_CYC);
        end else if (setup_done && is_write) begin
            t_val = tcnt(WR_PULSE_CYC);
        end else if (setup_done) begin
            t_val = is_array ? tcnt(ARRAY_ACCESS_CYC) : tcnt(FLAG_ACCESS_CYC);
        end else if ((st_q == ST_WRITE) && !busy_n) begin
            // restarts each blocked cycle so the hold counts from the release
            t_val = tcnt(WRITE_HOLD_CYC);
        end else if ((st_q == ST_READ) && !busy_n) begin
            t_val = tcnt(RELEASE_DATA_CYC);
        end else if (write_done || read_done) begin
            t_val = tcnt(FLAG_TURN_CYC);
        end else begin
            t_load = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q <= ST_IDLE;
            cmd_q <= '0;
            phase_rd_q <= 1'b0;
            ready_q <= 1'b1;
        end else begin
            unique case (st_q)
                ST_IDLE: begin
                    if (accept) begin
                        cmd_q <= cmd;
                        phase_rd_q <= 1'b0;
                        ready_q <= 1'b0;
                        st_q <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    if (setup_done) begin
                        st_q <= is_write ? ST_WRITE : ST_READ;
                    end
                end
                ST_WRITE: begin
                    if (write_done) begin
                        phase_rd_q <= is_take;
                        st_q <= ST_RECOV;
                    end
                end
                ST_READ: begin
                    if (read_done) begin
                        st_q <= ST_RECOV;
                    end
                end
                ST_RECOV: begin
                    if (again) begin
                        st_q <= ST_SETUP;
                    end else if (recov_done) begin
                        st_q <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    ready_q <= 1'b1;
                    st_q <= ST_IDLE;
                end
                default: begin
                    st_q <= ST_IDLE;
                    ready_q <= 1'b1;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs are kept disabled in every write so the data pins never contend
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pins_q.addr <= '0;
            pins_q.ce_n <= 1'b1;
            pins_q.rw_n <= 1'b1;
            pins_q.oe_n <= 1'b1;
            pins_q.upper_lane_sel_n <= 1'b1;
            pins_q.lower_lane_sel_n <= 1'b1;
            pins_q.flag_space_sel_n <= 1'b1;
            data_out_q <= '0;
            data_oe_n_q <= 1'b1;
        end else begin
            if (accept) begin
                pins_q.addr <= cmd.addr;
            end
            if (setup_done) begin
                pins_q.ce_n <= !is_array;
                pins_q.flag_space_sel_n <= is_array;
                {pins_q.upper_lane_sel_n, pins_q.lower_lane_sel_n} <=
                    is_array ? cmd_q.lane_n : LANES_OFF;
                if (is_write) begin
                    pins_q.rw_n <= 1'b0;
                    data_oe_n_q <= 1'b0;
                    data_out_q <= is_take ? FLAG_REQUEST : cmd_q.wdata;
                end else begin
                    pins_q.oe_n <= 1'b0;
                end
            end
            if (write_done || read_done) begin
                pins_q.rw_n <= 1'b1;
                pins_q.oe_n <= 1'b1;
                pins_q.ce_n <= 1'b1;
                pins_q.flag_space_sel_n <= 1'b1;
                pins_q.upper_lane_sel_n <= 1'b1;
                pins_q.lower_lane_sel_n <= 1'b1;
            end
            if (recov_done) begin
                data_oe_n_q <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rsp_q <= '0;
            rsp_valid_q <= 1'b0;
        end else begin
            if (read_done) begin
                rsp_q.rdata <= data_in;
                rsp_q.flag_held <= !data_in[0];
            end else if (write_done && is_take) begin
                // a new take must not finish on the grant seen by an earlier one
                rsp_q.flag_held <= 1'b0;
            end
            rsp_valid_q <= recov_done && !again;
        end
    end

    assign cmd_ready = ready_q;
    assign rsp_valid = rsp_valid_q;
    assign rsp = rsp_q;
    assign pins = pins_q;
    assign data_out = data_out_q;
    assign data_oe_n = data_oe_n_q;

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_addr_quiet: assert property (
        !$stable(pins_q.addr) |-> pins_q.rw_n && $past(pins_q.rw_n) && pins_q.oe_n)
        else $error("address moved while a strobe was active");
    chk_no_contend: assert property (
        !data_oe_n_q |-> pins_q.oe_n)
        else $error("data driven while device outputs enabled");
    chk_pulse_width: assert property (
        $rose(wr_act) |-> wr_act[*3])
        else $error("write pulse shorter than three cycles");
    chk_data_setup: assert property (
        $fell(wr_act) |-> $past(!data_oe_n_q, 2) && !data_oe_n_q)
        else $error("write data not set up before end of write");
    chk_enable_hold: assert property (
        ($fell(pins_q.ce_n) || $fell(pins_q.flag_space_sel_n)) |->
            (!pins_q.ce_n || !pins_q.flag_space_sel_n)[*3])
        else $error("select released before enable time");
    chk_flag_access: assert property (
        !pins_q.flag_space_sel_n |-> pins_q.ce_n && pins_q.upper_lane_sel_n
            && pins_q.lower_lane_sel_n)
        else $error("flag access with array selected");
    chk_priority_setup: assert property (
        ($fell(pins_q.rw_n) || $fell(pins_q.oe_n)) |->
            $stable(pins_q.addr) && $past(st_q == ST_SETUP, 2))
        else $error("access started without address settle time");
    chk_busy_blocks: assert property (
        wr_act && !busy_n |=> wr_act)
        else $error("write ended while port was blocked");
    chk_hold_after: assert property (
        $rose(busy_n) && wr_act |-> wr_act[*3])
        else $error("write not held after busy release");
    chk_take_readback: assert property (
        $fell(wr_act) && is_take |-> ##[1:12] (st_q == ST_READ))
        else $error("flag request not read back");
    chk_take_zero: assert property (
        wr_act && is_take |-> data_out_q == FLAG_REQUEST)
        else $error("flag request did not write zero");

endmodule : dpram_host

/* File: hw/dpram_host_pkg.sv */
// package: types and timing counts for the host side of a two-port static ram port
// assumes a 200 MHz clock and a device that answers purely by pin levels and delays
// Function
// - hold strobes high while address lines change
// - never drive data while device outputs drive
// - write pulse meets width and data setup
// - keep array or flag select for enable time
// - near-simultaneous flag writes grant no guarantee
// - settle address early to win arbitration
// - slave busy input precedes contending write start
// - hold write after busy release for hold time
// - flag taken writing zero, freed writing one
package dpram_host_pkg;

    localparam int unsigned CLK_PERIOD_NS = 5;

    // least time in ns to whole clock cycles, never below one
    function automatic int unsigned min_cycles(input int unsigned t_ns);
        int unsigned c;
        c = (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : min_cycles

    localparam int unsigned T_WRITE_PULSE_NS = 12;
    localparam int unsigned T_ENABLE_TO_END_NS = 12;
    localparam int unsigned T_DATA_SETUP_NS = 10;
    localparam int unsigned T_WRITE_HOLD_NS = 12;
    localparam int unsigned T_PRIORITY_SETUP_NS = 5;
    localparam int unsigned T_FLAG_WRITE_TO_READ_NS = 5;
    localparam int unsigned T_FLAG_ACCESS_NS = 35;
    localparam int unsigned T_ARRAY_ACCESS_NS = 35;
    localparam int unsigned T_RELEASE_TO_DATA_NS = 18;

    localparam int unsigned WR_PULSE_CYC = min_cycles(
        (T_WRITE_PULSE_NS > T_ENABLE_TO_END_NS) ? T_WRITE_PULSE_NS : T_ENABLE_TO_END_NS);
    localparam int unsigned DATA_SETUP_CYC = min_cycles(T_DATA_SETUP_NS);
    localparam int unsigned WRITE_HOLD_CYC = min_cycles(T_WRITE_HOLD_NS);
    localparam int unsigned PRIORITY_CYC = min_cycles(T_PRIORITY_SETUP_NS);
    localparam int unsigned FLAG_TURN_CYC = min_cycles(T_FLAG_WRITE_TO_READ_NS);
    localparam int unsigned FLAG_ACCESS_CYC = min_cycles(T_FLAG_ACCESS_NS);
    localparam int unsigned ARRAY_ACCESS_CYC = min_cycles(T_ARRAY_ACCESS_NS);
    localparam int unsigned RELEASE_DATA_CYC = min_cycles(T_RELEASE_TO_DATA_NS);

    localparam int unsigned TIMER_W = 4;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 16;

    localparam logic [DATA_W-1:0] FLAG_REQUEST = 16'h0000;
    localparam logic [1:0] LANES_OFF = 2'h3;

    typedef enum logic [2:0] {
        OP_RD = 3'h0,
        OP_WR = 3'h1,
        OP_FLAG_RD = 3'h2,
        OP_FLAG_WR = 3'h3,
        OP_FLAG_TAKE = 3'h4
    } op_t;

    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_SETUP = 7'h02,
        ST_WRITE = 7'h04,
        ST_READ = 7'h08,
        ST_RECOV = 7'h10,
        ST_DONE = 7'h20,
        ST_SPARE = 7'h40
    } state_t;

    typedef struct packed {
        op_t op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [1:0] lane_n;
    } cmd_t;

    typedef struct packed {
        logic [DATA_W-1:0] rdata;
        logic flag_held;
    } rsp_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic ce_n;
        logic rw_n;
        logic oe_n;
        logic upper_lane_sel_n;
        logic lower_lane_sel_n;
        logic flag_space_sel_n;
    } pins_t;

endpackage : dpram_host_pkg

/* File: hw/cycle_timer.sv */
// down counter: done is high once the loaded count has run out
// assumes load values fit TIMER_W bits
`timescale 1ns/1ps
module cycle_timer
    import dpram_host_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // control
    input wire logic load,
    input wire logic [TIMER_W-1:0] load_val,
    output logic done
);
    logic [TIMER_W-1:0] cnt_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
        end else if (load) begin
            cnt_q <= load_val;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    assign done = (cnt_q == '0);

endmodule : cycle_timer

/* File: verif/dpram_device_model.sv */
// device model: two-port ram array, master busy arbitration, eight flags
// assumes port a comes from the host under test and port b from the bench
`timescale 1ns/1ps
module dpram_device_model
    import dpram_host_pkg::*;
#(
    parameter int ANS_NS = 13
)
(
    // port a
    input wire pins_t a_pins,
    input wire logic [DATA_W-1:0] a_wdata,
    output logic [DATA_W-1:0] a_rdata,
    output logic a_rd_en,
    output logic a_busy_n,
    // port b
    input wire logic [ADDR_W-1:0] b_addr,
    input wire logic b_ce_n,
    input wire logic b_rw_n,
    input wire logic b_flag_n,
    input wire logic [DATA_W-1:0] b_wdata
);
    logic [DATA_W-1:0] mem [0:4095];
    logic [1:0] owner [0:7];
    logic [1:0] pend [0:7];
    logic b_first = 1'b1;
    logic [DATA_W-1:0] a_val;
    wire a_sel = !a_pins.ce_n && !(a_pins.upper_lane_sel_n && a_pins.lower_lane_sel_n);
    wire a_arr = a_sel && a_pins.flag_space_sel_n;
    wire a_flg = !a_sel && !a_pins.flag_space_sel_n;
    wire contend = a_pins.addr == b_addr && !a_pins.ce_n && !b_ce_n;
    wire a_block = contend && b_first;
    wire a_rd = !a_pins.oe_n && a_pins.rw_n && (a_arr || a_flg);
    wire a_fw = a_flg && !a_pins.rw_n;
    wire b_fw = b_ce_n && !b_flag_n && !b_rw_n;
    // master mode only: busy is always an output here
    assign #(ANS_NS) a_busy_n = !a_block;
    assign #(ANS_NS) a_rd_en = a_rd;
    initial for (int i = 0; i < 8; i++) begin
        owner[i] = 2'h0;
        pend[i] = 2'h0;
    end
    // whoever changed last while the other was selected loses
    always @(a_pins.addr or a_pins.ce_n) if (!b_ce_n) b_first = 1'b1;
    always @(b_addr or b_ce_n) b_first = a_pins.ce_n;
    always @* begin
        if (a_arr && !a_pins.rw_n && !a_block) begin
            if (!a_pins.lower_lane_sel_n) mem[a_pins.addr][7:0] = a_wdata[7:0];
            if (!a_pins.upper_lane_sel_n) mem[a_pins.addr][15:8] = a_wdata[15:8];
        end
        if (!b_ce_n && !b_rw_n && b_flag_n && !(contend && !b_first)) mem[b_addr] = b_wdata;
    end
    always @* begin
        a_val = {DATA_W{owner[a_pins.addr[2:0]] != 2'h1}};
        if (a_arr) a_val = mem[a_pins.addr];
        if (a_rd) a_rdata = a_val;
    end
    task automatic flag_wr(input int me, input logic [2:0] i, input logic val);
        int oth;
        oth = 3 - me;
        if (!val && owner[i] == 2'h0) owner[i] = 2'(me);
        else if (!val && owner[i] != 2'(me)) pend[i][me-1] = 1'b1;
        else if (val) begin
            pend[i][me-1] = 1'b0;
            if (owner[i] == 2'(me)) owner[i] = pend[i][oth-1] ? 2'(oth) : 2'h0;
            if (owner[i] == 2'(oth)) pend[i][oth-1] = 1'b0;
        end
    endtask : flag_wr
    always @(negedge a_fw) flag_wr(1, a_pins.addr[2:0], a_wdata[0]);
    always @(negedge b_fw) flag_wr(2, b_addr[2:0], b_wdata[0]);
endmodule : dpram_device_model

/* File: verif/dpram_host_tb.sv */
// testbench: one host port against the device model, far port driven here
// assumes a 200 MHz clock; inputs change at the falling edge
`timescale 1ns/1ps
module dpram_host_tb
    import dpram_host_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cmd_valid = 1'b0;
    cmd_t cmd = '0;
    logic cmd_ready, rsp_valid, data_oe_n, busy_n, a_rd_en;
    rsp_t rsp;
    pins_t pins;
    logic [DATA_W-1:0] data_out, data_in, a_rdata;
    logic [ADDR_W-1:0] b_addr = '0;
    logic b_ce_n = 1'b1;
    logic b_rw_n = 1'b1;
    logic b_flag_n = 1'b1;
    logic [DATA_W-1:0] b_wdata = '0;
    logic [ADDR_W-1:0] prev_addr = '0;
    int error_cnt = 0;
    int samples_checked = 0;
    always #2.5 clk = ~clk;
    // undriven data lines show the inverse of the device's read data
    assign data_in = !data_oe_n ? data_out : (a_rd_en ? a_rdata : ~a_rdata);
    dpram_host uut (.clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd),
        .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp(rsp), .pins(pins),
        .data_out(data_out), .data_oe_n(data_oe_n), .data_in(data_in), .busy_n(busy_n));
    dpram_device_model dev (.a_pins(pins), .a_wdata(data_out), .a_rdata(a_rdata),
        .a_rd_en(a_rd_en), .a_busy_n(busy_n), .b_addr(b_addr), .b_ce_n(b_ce_n),
        .b_rw_n(b_rw_n), .b_flag_n(b_flag_n), .b_wdata(b_wdata));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check
    task automatic print_verdict;
        $display("checks %0d, mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : print_verdict
    task automatic do_cmd(input op_t op, input logic [11:0] a, input logic [15:0] d,
        input logic [1:0] ln);
        int n;
        n = 0;
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd = '{op: op, addr: a, wdata: d, lane_n: ln};
        while (cmd_ready !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        cmd_valid = 1'b0;
        while (rsp_valid !== 1'b1 && n < 1000) begin
            @(negedge clk);
            n++;
        end
        check("answer in time", n < 1000, 1'b1);
    endtask : do_cmd
    // far port: address first, then a four cycle strobe
    task automatic b_write(input logic flg, input logic [11:0] a, input logic [15:0] d);
        @(negedge clk);
        b_addr = a;
        b_wdata = d;
        @(negedge clk);
        b_rw_n = 1'b0;
        if (flg) b_flag_n = 1'b0;
        else b_ce_n = 1'b0;
        repeat (4) @(negedge clk);
        b_rw_n = 1'b1;
        b_ce_n = 1'b1;
        b_flag_n = 1'b1;
    endtask : b_write
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_array;
        do_cmd(OP_WR, 12'h123, 16'hA5C3, 2'h0);
        do_cmd(OP_RD, 12'h123, 16'h0000, 2'h0);
        check("full word", rsp.rdata, 16'hA5C3);
        do_cmd(OP_WR, 12'h123, 16'h1111, 2'h2);
        do_cmd(OP_WR, 12'h123, 16'h2222, 2'h3);
        do_cmd(OP_RD, 12'h123, 16'h0000, 2'h0);
        check("lower lane only", rsp.rdata, 16'hA511);
        b_write(1'b0, 12'h040, 16'h3C3C);
        do_cmd(OP_RD, 12'h040, 16'h0000, 2'h0);
        check("peer data", rsp.rdata, 16'h3C3C);
        $display("array test done");
    endtask : t_array
    task automatic t_busy;
        @(negedge clk);
        b_addr = 12'h200;
        @(negedge clk);
        b_ce_n = 1'b0;
        fork
            do_cmd(OP_WR, 12'h200, 16'h7777, 2'h0);
            begin
                repeat (30) @(negedge clk);
                check("busy asserted", busy_n, 1'b0);
                check("write held", cmd_ready, 1'b0);
                b_ce_n = 1'b1;
                repeat (4) @(negedge clk);
                check("busy released", busy_n, 1'b1);
            end
        join
        do_cmd(OP_RD, 12'h200, 16'h0000, 2'h0);
        check("late write", rsp.rdata, 16'h7777);
        $display("busy test done");
    endtask : t_busy
    task automatic t_flag;
        do_cmd(OP_FLAG_RD, 12'h003, 16'h0000, 2'h3);
        check("free flag", rsp.rdata, 16'hFFFF);
        do_cmd(OP_FLAG_TAKE, 12'h003, 16'h0000, 2'h3);
        check("flag taken", rsp.flag_held, 1'b1);
        b_write(1'b1, 12'h003, 16'h0000);
        do_cmd(OP_FLAG_RD, 12'h003, 16'h0000, 2'h3);
        check("flag kept", rsp.rdata, 16'h0000);
        do_cmd(OP_FLAG_WR, 12'h003, 16'hFFFF, 2'h3);
        do_cmd(OP_FLAG_RD, 12'h003, 16'h0000, 2'h3);
        check("flag passed on", rsp.flag_held, 1'b0);
        fork
            do_cmd(OP_FLAG_TAKE, 12'h003, 16'h0000, 2'h3);
            begin
                repeat (30) @(negedge clk);
                b_write(1'b1, 12'h003, 16'hFFFF);
            end
        join
        check("flag handed back", rsp.flag_held, 1'b1);
        do_cmd(OP_FLAG_WR, 12'h003, 16'hFFFF, 2'h3);
        b_write(1'b1, 12'h003, 16'h0000);
        fork
            do_cmd(OP_FLAG_TAKE, 12'h003, 16'h0000, 2'h3);
            begin
                repeat (30) @(negedge clk);
                check("take waits", cmd_ready, 1'b0);
                b_write(1'b1, 12'h003, 16'hFFFF);
            end
        join
        check("second take", rsp.flag_held, 1'b1);
        do_cmd(OP_FLAG_WR, 12'h003, 16'hFFFF, 2'h3);
        $display("flag test done");
    endtask : t_flag
    ////////////////////////////////////////////////////////////////////////////////
    always @(negedge clk) begin
        if (!rst && pins.addr !== prev_addr) begin
            check("idle at address change", pins.rw_n | pins.ce_n
                | (pins.upper_lane_sel_n & pins.lower_lane_sel_n), 1'b1);
        end
        if (!rst && !data_oe_n) check("device quiet", a_rd_en, 1'b0);
        if (!rst && !pins.flag_space_sel_n) check("one space", pins.ce_n
            | (pins.upper_lane_sel_n & pins.lower_lane_sel_n), 1'b1);
        prev_addr = pins.addr;
    end
    initial begin
        repeat (10) @(negedge clk);
        rst = 1'b0;
        t_array();
        t_busy();
        t_flag();
        print_verdict();
    end
    initial begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        print_verdict();
    end
endmodule : dpram_host_tb
